// file: rtl/ldoc_consts.vh
// Constants for the linear regulator control block
`ifndef LDOC_CONSTS_VH
`define LDOC_CONSTS_VH
`define LDOC_NUM_REGS          4
`define LDOC_VCODE_W           6
`define LDOC_VCODE_DEFAULT     6'h18
`define LDOC_DELAY_W           3
`define LDOC_CLK_HZ            20000000
`define LDOC_DELAY_UNIT_MS     2
// One 2 ms delay unit at 20 MHz, sized for the tick counter
`define LDOC_DELAY_UNIT_CYCLES 16'h9c40
`define LDOC_TICK_W            16
`define LDOC_DCNT_W            7
`define LDOC_ST_OFF            2'h0
`define LDOC_ST_WAIT           2'h1
`define LDOC_ST_ON             2'h2
`endif

// file: rtl/ldoc_sync.v
// Three-stage input synchroniser with agreement filter
`default_nettype none
module ldoc_sync
(
  input  wire REF_CLK_IN,
  input  wire RST_IN,
  input  wire d_in,
  output reg  q_out
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_out  <= 1'b0;
    end
    else
    begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        q_out <= s3_reg;
    end
  end
endmodule // ldoc_sync
`default_nettype wire

// file: rtl/ldoc_top.v
// Control logic for four linear regulators
`include "ldoc_consts.vh"
`default_nettype none
module ldoc_top
#(
  parameter [`LDOC_TICK_W-1:0] DELAY_UNIT_CYCLES = `LDOC_DELAY_UNIT_CYCLES
)
(
  // Clock and reset
  input  wire                                       REF_CLK_IN,
  input  wire                                       RST_IN,
  // Register-side controls, one bit or field per regulator
  input  wire [`LDOC_NUM_REGS-1:0]                  ON_BIT_IN,
  input  wire [`LDOC_NUM_REGS*`LDOC_VCODE_W-1:0]    OUTPUT_VOLTAGE_CODE_IN,
  input  wire [`LDOC_NUM_REGS*`LDOC_DELAY_W-1:0]    TURN_ON_DELAY_IN,
  input  wire [`LDOC_NUM_REGS-1:0]                  DISCHARGE_ENABLE_IN,
  input  wire [`LDOC_NUM_REGS-1:0]                  LOW_QUIESCENT_SELECT_IN,
  input  wire [`LDOC_NUM_REGS-1:0]                  FAULT_INTERRUPT_ENABLE_IN,
  input  wire [`LDOC_NUM_REGS-1:0]                  POWER_GOOD_READ_IN,
  // Analog comparator inputs, asynchronous
  input  wire [`LDOC_NUM_REGS-1:0]                  OUTPUT_IN_REG_IN,
  // Regulator controls
  output reg  [`LDOC_NUM_REGS-1:0]                  REG_ENABLE_OUT,
  output reg  [`LDOC_NUM_REGS*`LDOC_VCODE_W-1:0]    OUTPUT_VOLTAGE_CODE_OUT,
  output reg  [`LDOC_NUM_REGS-1:0]                  DISCHARGE_ON_OUT,
  output reg  [`LDOC_NUM_REGS-1:0]                  LOW_QUIESCENT_OUT,
  // Status
  output reg  [`LDOC_NUM_REGS-1:0]                  POWER_GOOD_OUT,
  output reg                                        INTERRUPT_REQUEST_N_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Delay code to count of 2 ms ticks
  function [`LDOC_DCNT_W-1:0] delay_ticks;
    input [`LDOC_DELAY_W-1:0] code;
    begin
      if (code == 3'h0)
        delay_ticks = 7'h00;
      else
        delay_ticks = 7'h01 << (code - 3'h1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // On-bit edge decode
  function rise_seen;
    input on_now;
    input on_prev;
    begin
      rise_seen = on_now & ~on_prev;
    end
  endfunction

  function fall_seen;
    input on_now;
    input on_prev;
    begin
      fall_seen = ~on_now & on_prev;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Enable for the next cycle, shared so discharge never overlaps enable
  function enable_next;
    input                  en_now;
    input [1:0]            state;
    input [`LDOC_DCNT_W:0] cnt;
    input                  on_now;
    input                  on_prev;
    begin
      if (fall_seen(on_now, on_prev))
        enable_next = 1'b0;
      else if (state == `LDOC_ST_WAIT && cnt == 8'h00)
        enable_next = 1'b1;
      else
        enable_next = en_now;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise the power-good comparators
  wire [`LDOC_NUM_REGS-1:0] good_sync;
  genvar g;
  generate
    for (g = 0; g < `LDOC_NUM_REGS; g = g + 1)
    begin : gen_sync
      ldoc_sync u_sync
      (
        .REF_CLK_IN (REF_CLK_IN),
        .RST_IN     (RST_IN),
        .d_in       (OUTPUT_IN_REG_IN[g]),
        .q_out      (good_sync[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Shared 2 ms tick
  reg [`LDOC_TICK_W-1:0] tick_cnt_reg;
  reg                    tick_reg;

  always @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg == DELAY_UNIT_CYCLES - 16'h0001)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-regulator sequencing and fault state
  reg [`LDOC_NUM_REGS-1:0] on_prev_reg;
  reg [1:0]                state_reg [0:`LDOC_NUM_REGS-1];
  reg [`LDOC_DCNT_W:0]     dcnt_reg  [0:`LDOC_NUM_REGS-1];
  reg [`LDOC_NUM_REGS-1:0] pend_reg;
  reg [`LDOC_NUM_REGS-1:0] read_seen_reg;
  integer i;

  always @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      on_prev_reg             <= {`LDOC_NUM_REGS{1'b0}};
      pend_reg                <= {`LDOC_NUM_REGS{1'b0}};
      read_seen_reg           <= {`LDOC_NUM_REGS{1'b0}};
      REG_ENABLE_OUT          <= {`LDOC_NUM_REGS{1'b0}};
      DISCHARGE_ON_OUT        <= {`LDOC_NUM_REGS{1'b0}};
      LOW_QUIESCENT_OUT       <= {`LDOC_NUM_REGS{1'b0}};
      POWER_GOOD_OUT          <= {`LDOC_NUM_REGS{1'b0}};
      OUTPUT_VOLTAGE_CODE_OUT <= {`LDOC_NUM_REGS{`LDOC_VCODE_DEFAULT}};
      INTERRUPT_REQUEST_N_OUT <= 1'b1;
      for (i = 0; i < `LDOC_NUM_REGS; i = i + 1)
      begin
        state_reg[i] <= `LDOC_ST_OFF;
        dcnt_reg[i]  <= 8'h00;
      end
    end
    else
    begin
      on_prev_reg <= ON_BIT_IN;
      OUTPUT_VOLTAGE_CODE_OUT <= OUTPUT_VOLTAGE_CODE_IN;
      LOW_QUIESCENT_OUT <= LOW_QUIESCENT_SELECT_IN;
      POWER_GOOD_OUT <= good_sync & REG_ENABLE_OUT;
      for (i = 0; i < `LDOC_NUM_REGS; i = i + 1)
      begin
        case (state_reg[i])
          `LDOC_ST_OFF:
          begin
            if (rise_seen(ON_BIT_IN[i], on_prev_reg[i]))
            begin
              dcnt_reg[i]  <= {1'b0, delay_ticks(TURN_ON_DELAY_IN[i*3 +: 3])};
              state_reg[i] <= `LDOC_ST_WAIT;
            end
          end
          `LDOC_ST_WAIT:
          begin
            if (fall_seen(ON_BIT_IN[i], on_prev_reg[i]))
              state_reg[i] <= `LDOC_ST_OFF;
            else if (dcnt_reg[i] == 8'h00)
              state_reg[i] <= `LDOC_ST_ON;
            else if (tick_reg)
              dcnt_reg[i] <= dcnt_reg[i] - 8'h01;
          end
          `LDOC_ST_ON:
          begin
            if (fall_seen(ON_BIT_IN[i], on_prev_reg[i]))
              state_reg[i] <= `LDOC_ST_OFF;
          end
          default:
            state_reg[i] <= `LDOC_ST_OFF;
        endcase
        REG_ENABLE_OUT[i] <= enable_next(REG_ENABLE_OUT[i], state_reg[i], dcnt_reg[i],
                                         ON_BIT_IN[i], on_prev_reg[i]);
        DISCHARGE_ON_OUT[i] <= DISCHARGE_ENABLE_IN[i] &&
                               !enable_next(REG_ENABLE_OUT[i], state_reg[i], dcnt_reg[i],
                                            ON_BIT_IN[i], on_prev_reg[i]);
        if (FAULT_INTERRUPT_ENABLE_IN[i] && REG_ENABLE_OUT[i] && !good_sync[i])
        begin
          pend_reg[i] <= 1'b1;
          // A fresh fault forgets old reads, even one in its first cycle; later reads count
          if (!pend_reg[i])
            read_seen_reg[i] <= 1'b0;
          else if (POWER_GOOD_READ_IN[i])
            read_seen_reg[i] <= 1'b1;
        end
        else if (pend_reg[i])
        begin
          if (POWER_GOOD_READ_IN[i])
            read_seen_reg[i] <= 1'b1;
          if ((read_seen_reg[i] || POWER_GOOD_READ_IN[i]) &&
              (!REG_ENABLE_OUT[i] || good_sync[i]))
          begin
            pend_reg[i]      <= 1'b0;
            read_seen_reg[i] <= 1'b0;
          end
        end
      end
      INTERRUPT_REQUEST_N_OUT <= ~(|(pend_reg & FAULT_INTERRUPT_ENABLE_IN));
    end
  end
endmodule // ldoc_top
`default_nettype wire

// file: verif/ldoc_chk.sv
// Port assertions for the regulator control block
`default_nettype none
module ldoc_chk
(
  // Clock and reset
  input wire logic        REF_CLK_IN,
  input wire logic        RST_IN,
  // Watched ports
  input wire logic [3:0]  ON_BIT_IN,
  input wire logic [3:0]  DISCHARGE_ENABLE_IN,
  input wire logic [3:0]  LOW_QUIESCENT_SELECT_IN,
  input wire logic [3:0]  FAULT_INTERRUPT_ENABLE_IN,
  input wire logic [23:0] OUTPUT_VOLTAGE_CODE_IN,
  input wire logic [23:0] OUTPUT_VOLTAGE_CODE_OUT,
  input wire logic [3:0]  REG_ENABLE_OUT,
  input wire logic [3:0]  DISCHARGE_ON_OUT,
  input wire logic [3:0]  LOW_QUIESCENT_OUT,
  input wire logic [3:0]  POWER_GOOD_OUT,
  input wire logic        INTERRUPT_REQUEST_N_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [3:0] armed = FAULT_INTERRUPT_ENABLE_IN & REG_ENABLE_OUT;
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_drop; ##[1:2] !REG_ENABLE_OUT[0]; endsequence
  sequence s_start; $rose(ON_BIT_IN[0]) && !REG_ENABLE_OUT[0]; endsequence
  property p_off; $fell(ON_BIT_IN[0]) && REG_ENABLE_OUT[0] |-> s_drop; endproperty
  a_off: assert property (p_off) else $error("enable not dropped");
  property p_on; s_start |=> !REG_ENABLE_OUT[0]; endproperty
  a_on: assert property (p_on) else $error("enable too early");
  property p_code; !$past(RST_IN) && $stable(OUTPUT_VOLTAGE_CODE_IN) |->
    OUTPUT_VOLTAGE_CODE_OUT == OUTPUT_VOLTAGE_CODE_IN; endproperty
  a_code: assert property (p_code) else $error("code not applied");
  property p_dsc; !$past(RST_IN) |-> (DISCHARGE_ON_OUT & ~$past(DISCHARGE_ENABLE_IN)) == 4'h0;
  endproperty
  a_dsc: assert property (p_dsc) else $error("discharge unasked");
  property p_dson; (DISCHARGE_ON_OUT & REG_ENABLE_OUT) == 4'h0;
  endproperty
  a_dson: assert property (p_dson) else $error("discharge while on");
  property p_lq; !$past(RST_IN) |-> LOW_QUIESCENT_OUT == $past(LOW_QUIESCENT_SELECT_IN);
  endproperty
  a_lq: assert property (p_lq) else $error("lowq not copied");
  property p_pg; (POWER_GOOD_OUT & ~(REG_ENABLE_OUT | $past(REG_ENABLE_OUT))) == 4'h0;
  endproperty
  a_pg: assert property (p_pg) else $error("good while off");
  property p_irqf; $fell(INTERRUPT_REQUEST_N_OUT) |-> |($past(armed) | $past(armed, 2));
  endproperty
  a_irqf: assert property (p_irqf) else $error("request unarmed");
  property p_irqm; !INTERRUPT_REQUEST_N_OUT |-> |$past(FAULT_INTERRUPT_ENABLE_IN);
  endproperty
  a_irqm: assert property (p_irqm) else $error("request masked");
endmodule // ldoc_chk
bind ldoc_top ldoc_chk u_chk
(
  .REF_CLK_IN                (REF_CLK_IN),
  .RST_IN                    (RST_IN),
  .ON_BIT_IN                 (ON_BIT_IN),
  .DISCHARGE_ENABLE_IN       (DISCHARGE_ENABLE_IN),
  .LOW_QUIESCENT_SELECT_IN   (LOW_QUIESCENT_SELECT_IN),
  .FAULT_INTERRUPT_ENABLE_IN (FAULT_INTERRUPT_ENABLE_IN),
  .OUTPUT_VOLTAGE_CODE_IN    (OUTPUT_VOLTAGE_CODE_IN),
  .OUTPUT_VOLTAGE_CODE_OUT   (OUTPUT_VOLTAGE_CODE_OUT),
  .REG_ENABLE_OUT            (REG_ENABLE_OUT),
  .DISCHARGE_ON_OUT          (DISCHARGE_ON_OUT),
  .LOW_QUIESCENT_OUT         (LOW_QUIESCENT_OUT),
  .POWER_GOOD_OUT            (POWER_GOOD_OUT),
  .INTERRUPT_REQUEST_N_OUT   (INTERRUPT_REQUEST_N_OUT)
);
`default_nettype wire

// file: verif/ldoc_load.sv
// Regulator output model feeding the in-regulation comparators
`default_nettype none
module ldoc_load
(
  // Clock and controls
  input  wire logic       clk_in,
  input  wire logic [3:0] en_in,
  input  wire logic [3:0] fault_in,
  // Comparator result
  output var  logic [3:0] good_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ramp_reg;
  always @(posedge clk_in)
  begin
    ramp_reg <= en_in;
    good_out <= ramp_reg & en_in & ~fault_in;
  end
endmodule // ldoc_load
`default_nettype wire

// file: verif/ldoc_top_tb.sv
// Self-checking bench for the regulator control block
`default_nettype none
module ldoc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, irq_n;
  logic [3:0] on_bit, dsc_en, lowq, fie, rd, fault, en, dch, lq, pg, good;
  logic [11:0] dly;
  logic [23:0] vin, vout;
  int err_count, checks, n;
  ldoc_top #(.DELAY_UNIT_CYCLES(16'h0004)) uut (.REF_CLK_IN(clk), .RST_IN(rst),
    .ON_BIT_IN(on_bit), .OUTPUT_VOLTAGE_CODE_IN(vin), .TURN_ON_DELAY_IN(dly),
    .DISCHARGE_ENABLE_IN(dsc_en), .LOW_QUIESCENT_SELECT_IN(lowq),
    .FAULT_INTERRUPT_ENABLE_IN(fie), .POWER_GOOD_READ_IN(rd), .OUTPUT_IN_REG_IN(good),
    .REG_ENABLE_OUT(en), .OUTPUT_VOLTAGE_CODE_OUT(vout), .DISCHARGE_ON_OUT(dch),
    .LOW_QUIESCENT_OUT(lq), .POWER_GOOD_OUT(pg), .INTERRUPT_REQUEST_N_OUT(irq_n));
  ldoc_load u_load (.clk_in(clk), .en_in(en), .fault_in(fault), .good_out(good));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask
  task automatic wait_for(input logic [4:0] m, input logic [4:0] v);
    n = 0;
    while ((({irq_n, en}) & m) !== v)
    begin
      step(1);
      n++;
      if (n > 600)
      begin
        chk(24'h1, 24'h0);
        tally_and_finish();
      end
    end
  endtask
  task automatic t_enable;
    int c, lo;
    for (int i = 0; i < 4; i++)
    begin
      c = dly[3*i +: 3];
      lo = (c == 0) ? 0 : ((1 << (c - 1)) - 1) * 4;
      // bit was held low, now set
      on_bit[i] = 1'b1;
      wait_for(5'h1 << i, 5'h1 << i);
      chk(n >= lo && n <= lo + 8, 1'b1);
    end
    step(10);
    chk(pg, 4'hf);
    chk(lq, 4'h9);
  endtask
  task automatic t_fault;
    fie = 4'h3;
    fault = 4'h1;
    wait_for(5'h10, 5'h00);
    chk(pg[0], 1'b0);
    rd = 4'h1;
    step(1);
    rd = 4'h0;
    step(4);
    chk(irq_n, 1'b0);
    fault = 4'h0;
    wait_for(5'h10, 5'h10);
    fault = 4'h4;
    step(12);
    chk(irq_n, 1'b1);
    fault = 4'h6;
    wait_for(5'h10, 5'h00);
    fie = 4'h1;
    step(2);
    chk(irq_n, 1'b1);
    fie = 4'h3;
    step(2);
    chk(irq_n, 1'b0);
    fault = 4'h0;
    step(8);
    chk(irq_n, 1'b0);
    rd = 4'h2;
    step(1);
    rd = 4'h0;
    wait_for(5'h10, 5'h10);
  endtask
  task automatic t_off;
    dsc_en = 4'h3;
    step(2);
    chk(dch, 4'h0);
    on_bit[0] = 1'b0;
    step(3);
    chk(en, 4'he);
    chk(dch, 4'h1);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    {rst, on_bit, vin, dly, dsc_en, lowq, fie, rd, fault} = {1'b1, 28'h0, 12'hec8, 8'h09, 12'h0};
    step(8);
    chk(vout, 24'h618618);
    chk({en, dch, lq, pg, irq_n}, 17'h1);
    rst = 1'b0;
    step(2);
    t_enable();
    vin = 24'h00003f;
    step(2);
    chk(vout, 24'h00003f);
    t_fault();
    t_off();
    tally_and_finish();
  end
endmodule // ldoc_top_tb
`default_nettype wire
